// ===== verilog/sss_pkg.sv
package sss_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_POSX = 8'h0C;
    localparam logic [7:0] ADR_POSY = 8'h10;
    localparam logic [7:0] ADR_IRQS = 8'h14;
    localparam logic [7:0] ADR_IRQC = 8'h18;
    localparam logic [7:0] ADR_IRQE = 8'h1C;
    localparam logic [7:0] ADR_SETUP = 8'h20;
    localparam logic [7:0] ADR_TDLY = 8'h24;
    // Control fields, all in byte lane 0
    localparam int CTRL_TRIG = 0;
    localparam int CTRL_AUTO = 1;
    localparam int CTRL_CAL = 2;
    localparam int CTRL_MARK = 3;
    localparam int CTRL_PAT_LO = 4;
    // Command bits
    localparam int CMD_SWTRIG = 0;
    localparam int CMD_REINIT = 1;
    // Status fields
    localparam int STAT_IDX_LO = 0;
    localparam int STAT_RD_LO = 4;
    localparam int STAT_BUSY = 9;
    localparam int STAT_FAULT_LO = 12;
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_REJ = 2;
    localparam int NIRQ = 3;
    // Stage travel limit, 12000 nm
    localparam logic [13:0] POS_MAX = 14'h2EE0;
    // Fault codes
    localparam logic [3:0] FLT_NONE = 4'h0;
    localparam logic [3:0] FLT_MOVE = 4'h1;
    localparam logic [3:0] FLT_ABORT = 4'h2;
    localparam logic [3:0] FLT_CAL = 4'h3;
    // Reset values of timing registers, in clock cycles
    localparam logic [15:0] SETUP_RST = 16'h0100;
    localparam logic [15:0] TDLY_RST = 16'h0010;
    // Blanking after a move or calibration request
    localparam logic [23:0] MOVE_MASK = 24'h000008;
    // Positions per cycle
    localparam logic [4:0] SHOTS_ONE = 5'h01;
    localparam logic [4:0] SHOTS_PAIR = 5'h02;
    localparam logic [4:0] SHOTS_QUAD = 5'h04;
    localparam logic [4:0] SHOTS_NINE = 5'h09;
    localparam logic [4:0] SHOTS_SIXTEEN = 5'h10;

    // Shift patterns
    typedef enum logic [2:0] {
        PAT_OFF,
        MONO_QUAD_PATTERN,
        MONO_NINE_PATTERN,
        MONO_PAIR_HORIZONTAL,
        MONO_PAIR_VERTICAL,
        COLOUR_QUAD_PATTERN,
        COLOUR_SIXTEEN_PATTERN
    } sss_pat_e;

    // Number of images in one cycle of a pattern
    function automatic logic [4:0] sss_shots(input sss_pat_e p);
        unique case (p)
            MONO_QUAD_PATTERN, COLOUR_QUAD_PATTERN: return SHOTS_QUAD;
            MONO_NINE_PATTERN: return SHOTS_NINE;
            MONO_PAIR_HORIZONTAL, MONO_PAIR_VERTICAL: return SHOTS_PAIR;
            COLOUR_SIXTEEN_PATTERN: return SHOTS_SIXTEEN;
            default: return SHOTS_ONE;
        endcase
    endfunction : sss_shots
endpackage : sss_pkg

// ===== verilog/sss_pos_if.sv
`timescale 1ns/100ps
// Pattern step lookup between sequencer and table
interface sss_pos_if;
    sss_pkg::sss_pat_e pattern;
    logic [3:0] index;
    logic [13:0] x;
    logic [13:0] y;
    modport table_end(input pattern, input index, output x, output y);
    modport seq_end(output pattern, output index, input x, input y);
endinterface : sss_pos_if

// ===== verilog/sss_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for pin inputs
module sss_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage feeds only the second
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } sss_sync_s;

    sss_sync_s s_q, s_d;

    generate
        if (W < 1)
        begin : g_bad
            $error("sss_sync width must be at least one");
        end
    endgenerate

    // Shift chain
    always_comb
    begin
        s_d = s_q;
        s_d.meta = d;
        s_d.stab = s_q.meta;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign q = s_q.stab;
endmodule : sss_sync

// ===== verilog/sss_pos_table.sv
`timescale 1ns/100ps
// Stage offset for each step of each pattern
module sss_pos_table #(
    parameter logic [13:0] HALF_NM = 14'h0BB8,
    parameter logic [13:0] THIRD_NM = 14'h07D0,
    parameter logic [13:0] FULL_NM = 14'h1770
) (
    sss_pos_if.table_end pos
);
    logic [1:0] col3;
    logic [1:0] row3;

    // Every pattern must stay inside the stage travel
    generate
        if (3 * int'(HALF_NM) > int'(sss_pkg::POS_MAX) ||
            2 * int'(THIRD_NM) > int'(sss_pkg::POS_MAX) ||
            FULL_NM > sss_pkg::POS_MAX)
        begin : g_bad
            $error("sss_pos_table step exceeds stage travel");
        end
    endgenerate

    // Grid of three for the nine-shot pattern
    assign col3 = 2'(pos.index % 4'h3);
    assign row3 = 2'(pos.index / 4'h3);

    // Step zero is always the origin
    always_comb
    begin
        pos.x = 14'h0000;
        pos.y = 14'h0000;
        unique case (pos.pattern)
            sss_pkg::MONO_QUAD_PATTERN:
            begin
                pos.x = (pos.index[0] ^ pos.index[1]) ? HALF_NM : 14'h0000;
                pos.y = pos.index[1] ? HALF_NM : 14'h0000;
            end
            sss_pkg::MONO_NINE_PATTERN:
            begin
                pos.x = 14'(col3 * THIRD_NM);
                pos.y = 14'(row3 * THIRD_NM);
            end
            sss_pkg::MONO_PAIR_HORIZONTAL:
                pos.x = pos.index[0] ? HALF_NM : 14'h0000;
            sss_pkg::MONO_PAIR_VERTICAL:
                pos.y = pos.index[0] ? HALF_NM : 14'h0000;
            sss_pkg::COLOUR_QUAD_PATTERN:
            begin
                pos.x = (pos.index[0] ^ pos.index[1]) ? FULL_NM : 14'h0000;
                pos.y = pos.index[1] ? FULL_NM : 14'h0000;
            end
            sss_pkg::COLOUR_SIXTEEN_PATTERN:
            begin
                pos.x = 14'(pos.index[1:0] * HALF_NM);
                pos.y = 14'(pos.index[3:2] * HALF_NM);
            end
            default:
            begin
                pos.x = 14'h0000;
                pos.y = 14'h0000;
            end
        endcase
    end
endmodule : sss_pos_table

// ===== verilog/sss_top.sv
`timescale 1ns/100ps
// Function
// - Sequencing runs only with triggered acquisition
// - Six patterns, each sets cycle length
// - Colour patterns refused on mono sensor
// - Hold origin; advance per accepted trigger
// - Return to origin after last position
// - No sequencing during free-running acquisition
// - Auto mode generates remaining triggers internally
// - Auto cycle ignores triggers until readout
// - Manual mode: one image per trigger
// - Reinit command aborts cycle, back to wait
// - Reinit command runs sensor zero calibration
// - Auto zero adjust after each cycle
// - Readable fault code on abnormal stop
// - Manual X/Y positions limited 0..12000 nm
// - Marker writes image index into pixel zero
// - Marker in sequencing and in calibration, else untouched
module sss_top #(
    parameter logic COLOUR_SENSOR = 1'b0,
    parameter int MOVE_TIMEOUT = 100000,
    parameter int CAL_TIMEOUT = 1000000,
    parameter int PIX_W = 12,
    parameter logic [13:0] HALF_NM = 14'h0BB8,
    parameter logic [13:0] THIRD_NM = 14'h07D0,
    parameter logic [13:0] FULL_NM = 14'h1770
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic TRIG_LINE,
    input wire logic TRIG_LINK,
    input wire logic EXPOSE_DONE,
    input wire logic READOUT_DONE,
    input wire logic STAGE_AT_TARGET,
    input wire logic CAL_DONE,
    input wire logic [PIX_W-1:0] PIX_DATA_I,
    input wire logic PIX_VALID_I,
    input wire logic PIX_FIRST_I,
    output logic EXPOSE_START,
    output logic [13:0] STAGE_X,
    output logic [13:0] STAGE_Y,
    output logic STAGE_MOVE,
    output logic ZERO_CAL,
    output logic [PIX_W-1:0] PIX_DATA_O,
    output logic PIX_VALID_O,
    output logic IRQ
);
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EXPOSE,
        ST_MOVE,
        ST_SETTLE,
        ST_ARMED,
        ST_DRAIN,
        ST_CAL
    } sss_st_e;

    // Whole state of the block
    typedef struct packed {
        sss_st_e st;
        logic trig_on;
        logic auto_on;
        logic cal_on;
        logic mark_on;
        sss_pkg::sss_pat_e pat;
        logic [3:0] idx;
        logic [4:0] rd_cnt;
        logic [23:0] cnt;
        logic [15:0] setup;
        logic [15:0] tdly;
        logic [13:0] man_x;
        logic [13:0] man_y;
        logic [3:0] fault;
        logic [2:0] irq_st;
        logic [2:0] irq_en;
        logic last;
        logic line_prev;
        logic ack;
        logic [31:0] dat;
        logic expose;
        logic [13:0] x;
        logic [13:0] y;
        logic move;
        logic zcal;
        logic [PIX_W-1:0] pix;
        logic pvld;
        logic irq;
    } sss_state_s;

    sss_state_s s_q, s_d;
    logic [2:0] sync_q; // Line, at-target, cal-done after two flops
    logic bus_req;
    logic wr_en;
    logic sw_trig;
    logic reinit;
    logic ext_trig;
    logic seq_en;
    logic [4:0] shots;
    logic [3:0] last_idx;
    logic [2:0] pat_raw;
    logic pat_bad;
    logic [13:0] tgt_x;
    logic [13:0] tgt_y;
    logic [31:0] rdata;

    // Counters are 24 bits wide
    generate
        if (MOVE_TIMEOUT >= 2**24 || CAL_TIMEOUT >= 2**24 || PIX_W < 5)
        begin : g_bad
            $error("sss_top parameter out of range");
        end
    endgenerate

    // Pins from outside the clock domain
    sss_sync #(
        .W(3)
    ) u_sync (
        .clk(MCLK),
        .rst(RESET),
        .d({CAL_DONE, STAGE_AT_TARGET, TRIG_LINE}),
        .q(sync_q)
    );

    // Step lookup for the current index
    sss_pos_if pos ();
    assign pos.pattern = s_q.pat;
    assign pos.index = s_q.idx;

    sss_pos_table #(
        .HALF_NM(HALF_NM),
        .THIRD_NM(THIRD_NM),
        .FULL_NM(FULL_NM)
    ) u_tab (
        .pos(pos.table_end)
    );

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] lanes16(input logic [15:0] old);
        return {WB_SEL_I[1] ? WB_DAT_I[15:8] : old[15:8],
                WB_SEL_I[0] ? WB_DAT_I[7:0] : old[7:0]};
    endfunction : lanes16

    // Out-of-travel requests stop at the limit
    function automatic logic [13:0] clamp_pos(input logic [15:0] v);
        return (v > {2'b00, sss_pkg::POS_MAX}) ? sss_pkg::POS_MAX : v[13:0];
    endfunction : clamp_pos

    // Write takes effect at the edge the master sees ack
    assign bus_req = WB_CYC_I & WB_STB_I;
    assign wr_en = bus_req & WB_WE_I & s_q.ack;
    assign sw_trig = wr_en && WB_ADR_I == sss_pkg::ADR_CMD &&
                     WB_SEL_I[0] && WB_DAT_I[sss_pkg::CMD_SWTRIG];
    assign reinit = wr_en && WB_ADR_I == sss_pkg::ADR_CMD &&
                    WB_SEL_I[0] && WB_DAT_I[sss_pkg::CMD_REINIT];
    // All sources count as external ports
    assign ext_trig = sw_trig | (sync_q[0] & ~s_q.line_prev) | TRIG_LINK;
    assign seq_en = s_q.trig_on && s_q.pat != sss_pkg::PAT_OFF;
    assign shots = sss_pkg::sss_shots(s_q.pat);
    assign last_idx = 4'(shots - 5'h01);
    // Colour patterns on a mono sensor and unused codes are refused
    assign pat_raw = WB_DAT_I[sss_pkg::CTRL_PAT_LO +: 3];
    assign pat_bad = pat_raw > 3'(sss_pkg::COLOUR_SIXTEEN_PATTERN) ||
                     (!COLOUR_SENSOR &&
                      pat_raw >= 3'(sss_pkg::COLOUR_QUAD_PATTERN));

    // Stage target: manual when idle without sequencing, origin when idle, calibrating or after the last step, else pattern
    always_comb
    begin
        tgt_x = pos.x;
        tgt_y = pos.y;
        if (s_q.st == ST_IDLE && !seq_en)
        begin
            tgt_x = s_q.man_x;
            tgt_y = s_q.man_y;
        end
        else if (s_q.last || s_q.st == ST_IDLE || s_q.st == ST_CAL)
        begin
            tgt_x = 14'h0000;
            tgt_y = 14'h0000;
        end
    end

    // Register read mux; unmapped and write-only read as zero
    always_comb
    begin
        rdata = 32'h00000000;
        unique case (WB_ADR_I)
            sss_pkg::ADR_CTRL:
            begin
                rdata[sss_pkg::CTRL_TRIG] = s_q.trig_on;
                rdata[sss_pkg::CTRL_AUTO] = s_q.auto_on;
                rdata[sss_pkg::CTRL_CAL] = s_q.cal_on;
                rdata[sss_pkg::CTRL_MARK] = s_q.mark_on;
                rdata[sss_pkg::CTRL_PAT_LO +: 3] = s_q.pat;
            end
            sss_pkg::ADR_STAT:
            begin
                rdata[sss_pkg::STAT_IDX_LO +: 4] = s_q.idx;
                rdata[sss_pkg::STAT_RD_LO +: 5] = s_q.rd_cnt;
                rdata[sss_pkg::STAT_BUSY] = s_q.st != ST_IDLE;
                rdata[sss_pkg::STAT_FAULT_LO +: 4] = s_q.fault;
            end
            sss_pkg::ADR_POSX: rdata[13:0] = s_q.man_x;
            sss_pkg::ADR_POSY: rdata[13:0] = s_q.man_y;
            sss_pkg::ADR_IRQS: rdata[2:0] = s_q.irq_st;
            sss_pkg::ADR_IRQE: rdata[2:0] = s_q.irq_en;
            sss_pkg::ADR_SETUP: rdata[15:0] = s_q.setup;
            sss_pkg::ADR_TDLY: rdata[15:0] = s_q.tdly;
            default: rdata = 32'h00000000;
        endcase
    end

    // Next-state logic for bus, sequencer and pixel path
    always_comb
    begin
        logic [2:0] ev;
        logic [2:0] clr;
        ev = 3'h0;
        clr = 3'h0;
        s_d = s_q;
        s_d.expose = 1'b0;
        s_d.move = 1'b0;
        s_d.zcal = 1'b0;
        s_d.line_prev = sync_q[0];
        s_d.cnt = (s_q.cnt == 24'hFFFFFF) ? s_q.cnt : s_q.cnt + 24'h000001;
        // One-cycle ack per request, read data with it
        s_d.ack = bus_req & ~s_q.ack;
        if (bus_req && !s_q.ack)
            s_d.dat = rdata;
        // Register writes
        if (wr_en)
        begin
            unique case (WB_ADR_I)
                sss_pkg::ADR_CTRL:
                    if (WB_SEL_I[0])
                    begin
                        s_d.trig_on = WB_DAT_I[sss_pkg::CTRL_TRIG];
                        s_d.auto_on = WB_DAT_I[sss_pkg::CTRL_AUTO];
                        s_d.cal_on = WB_DAT_I[sss_pkg::CTRL_CAL];
                        s_d.mark_on = WB_DAT_I[sss_pkg::CTRL_MARK];
                        // Refused code keeps the old pattern
                        if (pat_bad)
                            ev[sss_pkg::IRQ_REJ] = 1'b1;
                        else
                            s_d.pat = sss_pkg::sss_pat_e'(pat_raw);
                    end
                sss_pkg::ADR_POSX:
                    s_d.man_x = clamp_pos(lanes16({2'b00, s_q.man_x}));
                sss_pkg::ADR_POSY:
                    s_d.man_y = clamp_pos(lanes16({2'b00, s_q.man_y}));
                sss_pkg::ADR_IRQC:
                    if (WB_SEL_I[0])
                        clr = WB_DAT_I[2:0];
                sss_pkg::ADR_IRQE:
                    if (WB_SEL_I[0])
                        s_d.irq_en = WB_DAT_I[2:0];
                sss_pkg::ADR_SETUP: s_d.setup = lanes16(s_q.setup);
                sss_pkg::ADR_TDLY: s_d.tdly = lanes16(s_q.tdly);
                default: s_d.irq_en = s_q.irq_en;
            endcase
        end
        // Readouts within a cycle index the marker
        if (READOUT_DONE && s_q.st != ST_IDLE)
            s_d.rd_cnt = s_q.rd_cnt + 5'h01;
        // Sequencer
        unique case (s_q.st)
            ST_IDLE:
                if (ext_trig && s_q.trig_on)
                begin
                    s_d.expose = 1'b1;
                    if (seq_en)
                    begin
                        s_d.st = ST_EXPOSE;
                        s_d.idx = 4'h0;
                        s_d.rd_cnt = 5'h00;
                        s_d.last = 1'b0;
                    end
                end
            ST_EXPOSE:
                if (EXPOSE_DONE)
                begin
                    s_d.st = ST_MOVE;
                    s_d.cnt = 24'h000000;
                    s_d.last = s_q.idx == last_idx;
                    if (s_q.idx != last_idx)
                        s_d.idx = s_q.idx + 4'h1;
                end
            ST_MOVE:
                if (s_q.cnt >= sss_pkg::MOVE_MASK && sync_q[1])
                begin
                    s_d.st = ST_SETTLE;
                    s_d.cnt = 24'h000000;
                end
                else if (s_q.cnt >= 24'(MOVE_TIMEOUT))
                begin
                    s_d.st = ST_IDLE;
                    s_d.fault = sss_pkg::FLT_MOVE;
                    ev[sss_pkg::IRQ_FAULT] = 1'b1;
                end
            ST_SETTLE:
                if (s_q.cnt >= {8'h00, s_q.setup})
                begin
                    s_d.st = s_q.last ? ST_DRAIN : ST_ARMED;
                    s_d.cnt = 24'h000000;
                end
            ST_ARMED:
                // Auto mode ignores external triggers
                if (s_q.auto_on ? s_q.cnt >= {8'h00, s_q.tdly} : ext_trig)
                begin
                    s_d.expose = 1'b1;
                    s_d.st = ST_EXPOSE;
                end
            ST_DRAIN:
                if (s_q.rd_cnt >= shots)
                begin
                    ev[sss_pkg::IRQ_DONE] = 1'b1;
                    s_d.st = s_q.cal_on ? ST_CAL : ST_IDLE;
                    s_d.zcal = s_q.cal_on;
                    s_d.cnt = 24'h000000;
                end
            ST_CAL:
                if (s_q.cnt >= sss_pkg::MOVE_MASK && sync_q[2])
                    s_d.st = ST_IDLE;
                else if (s_q.cnt >= 24'(CAL_TIMEOUT))
                begin
                    s_d.st = ST_IDLE;
                    s_d.fault = sss_pkg::FLT_CAL;
                    ev[sss_pkg::IRQ_FAULT] = 1'b1;
                end
        endcase
        // Sequencing switched off mid-cycle is an abnormal stop
        if (!seq_en && s_q.st != ST_IDLE && s_q.st != ST_CAL)
        begin
            s_d.st = ST_IDLE;
            s_d.expose = 1'b0;
            s_d.fault = sss_pkg::FLT_ABORT;
            ev[sss_pkg::IRQ_FAULT] = 1'b1;
        end
        // Reinit aborts anything and recalibrates
        if (reinit)
        begin
            s_d.st = ST_CAL;
            s_d.zcal = 1'b1;
            s_d.expose = 1'b0;
            s_d.cnt = 24'h000000;
            s_d.idx = 4'h0;
            s_d.rd_cnt = 5'h00;
            s_d.last = 1'b0;
            s_d.fault = sss_pkg::FLT_NONE;
        end
        // Stage drive, move pulse on any target change
        s_d.x = tgt_x;
        s_d.y = tgt_y;
        s_d.move = (tgt_x != s_q.x) || (tgt_y != s_q.y);
        // Pixel zero carries the image index
        s_d.pvld = PIX_VALID_I;
        s_d.pix = PIX_DATA_I;
        if (s_q.mark_on && s_q.st != ST_IDLE && PIX_FIRST_I)
            s_d.pix = PIX_W'(s_q.rd_cnt);
        // Set wins over clear
        s_d.irq_st = (s_q.irq_st & ~clr) | ev;
        s_d.irq = |(s_d.irq_st & s_d.irq_en);
    end

    // State register
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.pat <= sss_pkg::PAT_OFF;
            s_q.setup <= sss_pkg::SETUP_RST;
            s_q.tdly <= sss_pkg::TDLY_RST;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from the state register
    assign WB_DAT_O = s_q.dat;
    assign WB_ACK_O = s_q.ack;
    assign EXPOSE_START = s_q.expose;
    assign STAGE_X = s_q.x;
    assign STAGE_Y = s_q.y;
    assign STAGE_MOVE = s_q.move;
    assign ZERO_CAL = s_q.zcal;
    assign PIX_DATA_O = s_q.pix;
    assign PIX_VALID_O = s_q.pvld;
    assign IRQ = s_q.irq;

    // Checks on the sequencer
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    a_expose_needs_trig: assert property (
        !s_q.trig_on |=> !EXPOSE_START)
        else $error("exposure started with trigger mode off");
    a_idle_at_origin: assert property (
        (s_q.st == ST_IDLE && seq_en) [*2] |-> STAGE_X == 14'h0000 &&
        STAGE_Y == 14'h0000)
        else $error("stage away from origin while waiting");
    a_drain_origin: assert property (
        s_q.st == ST_DRAIN |-> STAGE_X == 14'h0000 && STAGE_Y == 14'h0000)
        else $error("stage not at origin after last position");
    a_auto_no_ext: assert property (
        s_q.auto_on && s_q.st inside {ST_MOVE, ST_SETTLE, ST_DRAIN} &&
        !reinit |=> !EXPOSE_START)
        else $error("exposure during auto cycle gap");
    a_reinit_cal: assert property (
        reinit |=> ZERO_CAL && s_q.st == ST_CAL && s_q.idx == 4'h0)
        else $error("reinit did not start calibration");
    a_pos_limit: assert property (
        STAGE_X <= sss_pkg::POS_MAX && STAGE_Y <= sss_pkg::POS_MAX)
        else $error("stage target beyond travel");
    a_marker_index: assert property (
        s_q.mark_on && s_q.st != ST_IDLE && PIX_FIRST_I |=>
        PIX_DATA_O == PIX_W'($past(s_q.rd_cnt)))
        else $error("pixel zero does not carry image index");
    a_marker_off: assert property (
        !s_q.mark_on |=> PIX_DATA_O == $past(PIX_DATA_I))
        else $error("pixel data changed with marker off");
    a_settle_time: assert property (
        s_q.st == ST_SETTLE && s_d.st == ST_ARMED |->
        s_q.cnt >= {8'h00, s_q.setup})
        else $error("armed before setup time elapsed");

    c_cycle_done: cover property (
        s_q.st == ST_DRAIN ##1 s_q.st == ST_IDLE);
    c_auto_trig: cover property (
        s_q.auto_on && s_q.st == ST_ARMED ##1 EXPOSE_START);
    c_fault: cover property (s_q.irq_st[sss_pkg::IRQ_FAULT]);
    c_auto_cal: cover property (s_q.st == ST_DRAIN ##1 ZERO_CAL);
endmodule : sss_top

// ===== sim/sss_stage_model.sv
`timescale 1ns/100ps
// Far side: stage, sensor readout and calibrator
module sss_stage_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic xs,
    input wire logic mv,
    input wire logic zc,
    output logic ed,
    output logic rdn,
    output logic at,
    output logic cd
);
    logic [3:0] mv_q; // Settle countdown
    logic [3:0] cal_q; // Calibration countdown
    // Levels drop at once; stage slower than blanking
    always_ff @(posedge clk)
    begin
        ed <= xs;
        rdn <= ed;
        mv_q <= mv ? 4'hC : mv_q - 4'(mv_q != 4'h0);
        cal_q <= zc ? 4'hC : cal_q - 4'(cal_q != 4'h0);
        at <= rst | (~mv & (at | mv_q == 4'h1));
        cd <= rst | (~zc & (cd | cal_q == 4'h1));
    end
endmodule : sss_stage_model

// ===== sim/sss_top_bench.sv
`timescale 1ns/100ps
// Register rows first, then whole shift cycles
module sss_top_bench;
    logic clk, rst, cyc, we, lnk, ack, xs, mv, zc, irq, ed, rdn, at, cd;
    logic ln, pf, pvo;
    logic mk = 1'b0; // Marker expected on pixel zero
    logic [11:0] pd = 12'h000; // Free-running pixel value
    logic [11:0] po;
    logic [15:0] mlog = 16'h0000; // Marker values seen
    logic [7:0] adr;
    logic [31:0] wd, rdat, rv;
    logic [13:0] sx, sy;
    int error_cnt = 0;
    int check_count = 0;
    int nx = 0; // Exposures seen
    int nz = 0; // Calibrations seen
    // Write address, data, read address, expected
    logic [79:0] rows [6] = '{
        {8'h0C, 32'h3000, 8'h0C, 32'h2EE0},
        {8'h10, 32'h0123, 8'h10, 32'h0123},
        {8'h40, 32'hFFFF, 8'h40, 32'h0000},
        {8'h00, 32'h0051, 8'h14, 32'h0004},
        {8'h18, 32'h0007, 8'h14, 32'h0000},
        {8'h00, 32'h0011, 8'h00, 32'h0011}};
    sss_top #(.MOVE_TIMEOUT(200), .CAL_TIMEOUT(200)) u_sss_top (
        .MCLK(clk), .RESET(rst), .WB_ADR_I(adr), .WB_DAT_I(wd),
        .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .TRIG_LINE(ln),
        .TRIG_LINK(lnk), .EXPOSE_DONE(ed), .READOUT_DONE(rdn),
        .STAGE_AT_TARGET(at), .CAL_DONE(cd), .PIX_DATA_I(pd),
        .PIX_VALID_I(pf), .PIX_FIRST_I(pf), .EXPOSE_START(xs),
        .STAGE_X(sx), .STAGE_Y(sy), .STAGE_MOVE(mv), .ZERO_CAL(zc),
        .PIX_DATA_O(po), .PIX_VALID_O(pvo), .IRQ(irq));
    sss_stage_model u_sss_stage_model (.clk(clk), .rst(rst), .xs(xs),
        .mv(mv), .zc(zc), .ed(ed), .rdn(rdn), .at(at), .cd(cd));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Pulse counters; pixel zero arrives with each readout
    always @(posedge clk)
    begin
        nx <= nx + int'(xs);
        nz <= nz + int'(zc);
        pd <= pd + 12'h001;
        pf <= ed;
        if (pvo && mk)
            mlog <= mlog | (16'h0001 << po[3:0]);
        else if (pvo)
            chk({20'h0, po}, {20'h0, pd - 12'h001});
    end
    // Single cycle; held until ack is sampled high, released there
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        // A missing answer counts against the run
        if (ack !== 1'b1)
            error_cnt++;
        rv = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask : chk
    // Link trigger, then idle spacing
    task automatic tr(input int k);
        lnk <= 1'b1;
        @(posedge clk);
        lnk <= 1'b0;
        repeat (k) @(posedge clk);
    endtask : tr
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial
    begin
        #40000;
        error_cnt++;
        conclude();
    end
    initial
    begin
        {rst, cyc, we, lnk, ln, adr, wd} = {5'h10, 40'h0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i])
        begin
            wb(1'b1, rows[i][79:72], rows[i][71:40]);
            wb(1'b0, rows[i][39:32], 32'h0);
            chk(rv, rows[i][31:0]);
        end
        chk({18'h0, sx}, 32'h0);
        $display("table done");
        wb(1'b1, 8'h20, 32'h10);
        wb(1'b1, 8'h1C, 32'h1);
        tr(100);
        chk({31'h0, |{sx, sy}}, 32'h1);
        repeat (3) tr(100);
        chk(nx, 4);
        chk({31'h0, irq}, 32'h1);
        chk({4'h0, sx, sy}, 32'h0);
        chk(nz, 0);
        wb(1'b1, 8'h18, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("manual done");
        mk <= 1'b1;
        wb(1'b1, 8'h00, 32'h1F);
        tr(30);
        tr(400);
        chk(nx, 8);
        chk(nz, 1);
        chk({16'h0, mlog}, 32'h000F);
        mk <= 1'b0;
        wb(1'b1, 8'h00, 32'h10);
        tr(100);
        chk(nx, 8);
        wb(1'b1, 8'h00, 32'h11);
        tr(20);
        wb(1'b1, 8'h04, 32'h2);
        repeat (100) @(posedge clk);
        chk(nz, 2);
        // Line pin trigger after the reinit, one rising edge
        ln <= 1'b1;
        repeat (4) @(posedge clk);
        ln <= 1'b0;
        repeat (100) @(posedge clk);
        chk(nx, 10);
        $display("auto and reinit done");
        // Reset in mid-cycle brings back the reset values
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, 8'h20, 32'h0);
        chk(rv, 32'h0100);
        wb(1'b0, 8'h00, 32'h0);
        chk(rv, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        chk(rv, 32'h0);
        chk({4'h0, sx, sy}, 32'h0);
        $display("reset done");
        conclude();
    end
endmodule : sss_top_bench
